// ---- hdl/programmed_io_channel_attach.sv ----
// device-side attachment for programmed transfers on the service group
// Contract
// - one sequence moves exactly one byte or word
// - select on line 16 when lines 8-15 match
// - decode command, check write parity, form condition code
// - selection and examination alone change nothing
// - writes act on strobe, except device reset
// - reset or prepare fixes request before strobe drops
// - drive condition code and read data before return
// - hold code and data until gate, strobe drop
// - raise gate return within 3 us of gate
// - release buses, then drop return within 3 us
// - finish all command actions before return drops
// - interrupt poll inhibits other sequences until serviced; there is no poll logic here, only a sequence in progress or a machine check inhibits selection
// - burst cycle steal blocks all other sequences; there is no burst logic here, only a sequence in progress or a machine check blocks a selection
// - service and poll groups handled independently
// - machine check clears logic, keeps prepare level
`timescale 1ns/1ns
`default_nettype none
`include "dpt_params.svh"
module programmed_io_channel_attach (
    input  wire logic                CLOCK,
    input  wire logic                SRST,
    input  wire logic [`ADDR_W-1:0]  ADDR_IN,
    input  wire logic                ADDR_SEL_IN,
    input  wire logic [`DATA_W-1:0]  DATA_IN,
    input  wire logic [`PAR_W-1:0]   DATA_PAR_IN,
    input  wire logic                ADDR_GATE,
    input  wire logic                DATA_STROBE,
    input  wire logic                MACHINE_CHECK_TAG,
    input  wire logic [`CODE_W-1:0]  DEVICE_ADDR,
    input  wire logic [`DATA_W-1:0]  RD_DATA,
    input  wire logic                USER_BUSY,
    input  wire logic                INT_EVENT,
    output logic                     ADDR_GATE_RETURN,
    output logic [`CC_W-1:0]         CC_OUT,
    output logic                     CC_OE,
    output logic [`DATA_W-1:0]       DATA_OUT,
    output logic [`PAR_W-1:0]        DATA_PAR_OUT,
    output logic                     DATA_OE,
    output logic [`LEVELS-1:0]       REQUEST_OUT,
    output logic                     CMD_STROBE,
    output logic [`CODE_W-1:0]       CMD_CODE,
    output logic [`DATA_W-1:0]       CMD_DATA,
    output logic                     DEVICE_RESET
);
    localparam int AGR_MAX  = `AGR_MAX_CYC;
    localparam int DROP_MAX = `DROP_MAX_CYC;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    dpt_pkg::seq_state_t state;
    dpt_pkg::seq_state_t next_state;
    dpt_pkg::command_t   cmd;
    dpt_pkg::command_t   next_cmd;
    dpt_pkg::verdict_t   verdict;
    dpt_pkg::verdict_t   vreg;
    dpt_pkg::verdict_t   next_vreg;

    logic [`TAG_N-1:0]      tag_q;
    logic [`TAG_N-1:0]      tag_rise;
    logic [`BUS_SYNC_W-1:0] bus_q;
    logic                   acted;
    logic                   pending;
    logic                   prep_en;
    logic [`LVL_W-1:0]      prep_lvl;
    logic                   next_pending;
    logic                   next_en;
    logic [`LVL_W-1:0]      next_lvl;
    logic [`LEVELS-1:0]     next_request;

    // tags and buses both pass two stages; the gate deskew covers the skew
    sig_sync #(.WIDTH(`TAG_N)) u_tag_sync (
        .clk  (CLOCK),
        .srst (SRST),
        .din  ({MACHINE_CHECK_TAG, DATA_STROBE, ADDR_GATE, ADDR_SEL_IN}),
        .q    (tag_q),
        .rise (tag_rise),
        .fall ()
    );

    sig_sync #(.WIDTH(`BUS_SYNC_W)) u_bus_sync (
        .clk  (CLOCK),
        .srst (SRST),
        .din  ({DEVICE_ADDR, DATA_PAR_IN, DATA_IN, ADDR_IN}),
        .q    (bus_q),
        .rise (),
        .fall ()
    );

    wire [`ADDR_W-1:0] addr_q = bus_q[`ADDR_W-1:0];
    wire [`DATA_W-1:0] data_q = bus_q[`ADDR_W +: `DATA_W];
    wire [`PAR_W-1:0]  par_q  = bus_q[`ADDR_W+`DATA_W +: `PAR_W];
    wire [`CODE_W-1:0] dev_q  = bus_q[`BUS_SYNC_W-1 -: `CODE_W];

    wire sel_q   = tag_q[`TAG_SEL];
    wire ag_q    = tag_q[`TAG_AG];
    wire ds_q    = tag_q[`TAG_DS];
    wire halt_q  = tag_q[`TAG_HALT];
    wire ag_rise = tag_rise[`TAG_AG];
    wire ds_rise = tag_rise[`TAG_DS];

    wire addr_match = addr_q[`DEVADDR_MSB:`DEVADDR_LSB] == dev_q;
    wire selecting  = sel_q & addr_match & ~halt_q;

    cmd_decode u_decode (
        .cmd     (cmd),
        .busy    (USER_BUSY),
        .verdict (verdict)
    );

    // only this handshake lives here; poll-group logic never stalls it
    always_comb begin
        next_state = state;
        unique case (state)
            dpt_pkg::ST_IDLE:
                if (selecting) next_state = dpt_pkg::ST_SELECTED;
            dpt_pkg::ST_SELECTED:
                // gate never came: channel gave up and dropped the buses
                if (!sel_q) next_state = dpt_pkg::ST_IDLE;
                else if (ag_rise) next_state = dpt_pkg::ST_DRIVE;
            dpt_pkg::ST_DRIVE:
                next_state = dpt_pkg::ST_RETURN;
            dpt_pkg::ST_RETURN:
                // strobe may never come on a read parity error
                if (!ag_q && !ds_q) next_state = dpt_pkg::ST_RELEASE;
            dpt_pkg::ST_RELEASE:
                next_state = dpt_pkg::ST_FINISH;
            dpt_pkg::ST_FINISH:
                // wait for line 16 to drop so the held bus cannot reselect
                if (!sel_q) next_state = dpt_pkg::ST_IDLE;
            default:
                next_state = dpt_pkg::ST_IDLE;
        endcase
        if (halt_q) next_state = dpt_pkg::ST_IDLE;
    end

    // a selection is taken from idle whenever line 16 is up, lines 8-15 match and no machine check is up
    wire enter_select = (state == dpt_pkg::ST_IDLE) && selecting;
    wire enter_drive  = (state == dpt_pkg::ST_SELECTED) && sel_q
                        && ag_rise && !halt_q;
    wire drive_next   = (next_state == dpt_pkg::ST_DRIVE)
                        || (next_state == dpt_pkg::ST_RETURN);
    wire agr_next     = (next_state == dpt_pkg::ST_RETURN)
                        || (next_state == dpt_pkg::ST_RELEASE);

    // device reset is the one command that acts on the gate
    wire reset_fire = enter_drive && verdict.accept && verdict.is_reset;
    // everything else acts once, on the strobe, inside the return window
    wire act_fire   = (state == dpt_pkg::ST_RETURN) && ds_rise && !acted
                      && vreg.accept && !vreg.is_reset && !halt_q;
    wire prep_fire  = act_fire && vreg.is_prepare;
    wire user_fire  = act_fire && !vreg.is_prepare && !vreg.is_status;

    assign next_cmd  = enter_select ?
                       dpt_pkg::command_t'{code: addr_q[`CMD_MSB:`CMD_LSB],
                         data: data_q, par: par_q} : cmd;
    assign next_vreg = enter_drive ? verdict : vreg;

    wire [`DATA_W-1:0] status_word = {{(`DATA_W-`STAT_PEND_BIT-1){1'b0}},
                                      pending, prep_en, prep_lvl};
    wire [`DATA_W-1:0] rd_word     = verdict.is_status ? status_word : RD_DATA;
    wire [`PAR_W-1:0]  rd_par      = {~^rd_word[15:8], ~^rd_word[7:0]};

    // a new event in the clearing cycle survives the clear
    assign next_pending = INT_EVENT | (pending & ~reset_fire & ~halt_q);
    // prepare level and enable survive a machine check
    assign next_en  = prep_fire ? cmd.data[`PREP_EN_BIT] : prep_en;
    assign next_lvl = prep_fire ? cmd.data[`PREP_LVL_MSB:`PREP_LVL_LSB]
                                : prep_lvl;

    genvar lv;
    generate
        for (lv = 0; lv < `LEVELS; lv++) begin : g_req
            // request follows the new level in the same edge as prepare
            assign next_request[lv] = next_pending & next_en
                                      & (next_lvl == `LVL_W'(lv));
        end
    endgenerate

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state <= dpt_pkg::ST_IDLE;
            cmd   <= '0;
            vreg  <= '0;
            acted <= 1'b0;
        end else begin
            state <= next_state;
            cmd   <= next_cmd;
            vreg  <= next_vreg;
            acted <= (next_state != dpt_pkg::ST_IDLE) & (acted | act_fire);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            CC_OE            <= 1'b0;
            CC_OUT           <= `CC_NONE;
            DATA_OE          <= 1'b0;
            DATA_OUT         <= '0;
            DATA_PAR_OUT     <= '0;
            ADDR_GATE_RETURN <= 1'b0;
        end else begin
            CC_OE            <= drive_next;
            CC_OUT           <= drive_next ? next_vreg.cc : `CC_NONE;
            DATA_OE          <= drive_next & next_vreg.accept
                                & next_vreg.is_read;
            DATA_OUT         <= !drive_next ? '0 :
                                enter_drive ? rd_word : DATA_OUT;
            DATA_PAR_OUT     <= !drive_next ? '0 :
                                enter_drive ? rd_par : DATA_PAR_OUT;
            ADDR_GATE_RETURN <= agr_next;
        end
    end

    // strobe actions land on the strobe edge, device reset on the gate edge, well before return falls
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            pending      <= 1'b0;
            prep_en      <= 1'b0;
            prep_lvl     <= '0;
            REQUEST_OUT  <= '0;
            CMD_STROBE   <= 1'b0;
            CMD_CODE     <= '0;
            CMD_DATA     <= '0;
            DEVICE_RESET <= 1'b0;
        end else begin
            pending      <= next_pending;
            prep_en      <= next_en;
            prep_lvl     <= next_lvl;
            REQUEST_OUT  <= next_request;
            CMD_STROBE   <= user_fire;
            CMD_CODE     <= user_fire ? cmd.code : CMD_CODE;
            CMD_DATA     <= user_fire ? cmd.data : CMD_DATA;
            DEVICE_RESET <= reset_fire;
        end
    end

    // checks
    logic [1:0] xfer_count;
    always_ff @(posedge CLOCK) begin
        if (SRST || state == dpt_pkg::ST_IDLE) xfer_count <= '0;
        else if (act_fire && xfer_count != 2'h3) begin
            xfer_count <= xfer_count + 2'h1;
        end
    end

    sequence s_bus_driven;
        CC_OE && !ADDR_GATE_RETURN;
    endsequence

    sequence s_return_up;
        CC_OE && ADDR_GATE_RETURN;
    endsequence

    property p_drive_then_return;
        @(posedge CLOCK) disable iff (SRST)
        enter_drive |=> s_bus_driven ##1 s_return_up;
    endproperty

    chk_cc_before_return: assert property (p_drive_then_return)
        else $error("condition code not driven ahead of gate return");

    chk_return_bound: assert property (
        (state == dpt_pkg::ST_SELECTED && ag_rise && !halt_q && sel_q)
        |-> ##[1:AGR_MAX] ADDR_GATE_RETURN)
        else $error("gate return late");

    chk_cc_stable: assert property (@(posedge CLOCK) disable iff (SRST)
        (CC_OE && $past(CC_OE) && !halt_q)
        |-> $stable(CC_OUT) && $stable(DATA_OUT) && $stable(DATA_OE))
        else $error("condition code or read data changed while held");

    chk_release_first: assert property (
        $fell(ADDR_GATE_RETURN) && !$past(halt_q)
        |-> !CC_OE && !DATA_OE && $past(!CC_OE))
        else $error("buses still driven when gate return fell");

    chk_drop_bound: assert property (@(posedge CLOCK) disable iff (SRST)
        (state == dpt_pkg::ST_RETURN && !ag_q && !ds_q)
        |-> ##[1:DROP_MAX] !ADDR_GATE_RETURN)
        else $error("gate return did not drop in time");

    chk_one_transfer: assert property (
        xfer_count <= 2'h1)
        else $error("more than one transfer in a sequence");

    chk_quiet_select: assert property (
        (state == dpt_pkg::ST_SELECTED || state == dpt_pkg::ST_IDLE)
        |=> !CMD_STROBE && $stable(prep_lvl) && $stable(prep_en))
        else $error("action taken before gate or strobe");

    chk_select_match: assert property (
        (state == dpt_pkg::ST_IDLE && next_state == dpt_pkg::ST_SELECTED)
        |-> sel_q && addr_match)
        else $error("selected without a device address match");

    chk_reset_drops: assert property (
        reset_fire && !INT_EVENT |=> DEVICE_RESET && !pending
            && REQUEST_OUT == '0)
        else $error("request not dropped by device reset");

    chk_halt_clears: assert property (
        halt_q |=> state == dpt_pkg::ST_IDLE && !ADDR_GATE_RETURN && !CC_OE
                   && $stable(prep_lvl))
        else $error("machine check did not clear the interface");

    chk_strobe_edge: assert property (
        CMD_STROBE |-> $past(ds_rise) && $past(state == dpt_pkg::ST_RETURN))
        else $error("user strobe not tied to a synchronised strobe edge");
endmodule
`default_nettype wire

// ---- hdl/dpt_params.svh ----
// timing, field and encoding constants for the programmed transfer attachment
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH

`define CLK_PERIOD_NS   50
`define T_AGR_MAX_NS    3000
`define T_DROP_MAX_NS   3000
`define AGR_MAX_CYC     (`T_AGR_MAX_NS / `CLK_PERIOD_NS)
`define DROP_MAX_CYC    (`T_DROP_MAX_NS / `CLK_PERIOD_NS)

`define ADDR_W          16
`define DATA_W          16
`define CODE_W          8
`define CC_W            3
`define LVL_W           4
`define LEVELS          16
`define PAR_W           2

`define CMD_MSB         7
`define CMD_LSB         0
`define DEVADDR_MSB     15
`define DEVADDR_LSB     8
`define CMD_DIR_BIT     7

`define TAG_SEL         0
`define TAG_AG          1
`define TAG_DS          2
`define TAG_HALT        3
`define TAG_N           4
`define BUS_SYNC_W      42

`define CODE_WRITE_DATA 8'h01
`define CODE_PREPARE    8'h02
`define CODE_DEV_RESET  8'h03
`define CODE_READ_DATA  8'h81
`define CODE_READ_STAT  8'h82

`define CC_NONE         3'h0
`define CC_BUSY         3'h1
`define CC_REJECT       3'h2
`define CC_PARITY       3'h3
`define CC_OK           3'h7

`define PREP_LVL_MSB    3
`define PREP_LVL_LSB    0
`define PREP_EN_BIT     4
`define STAT_PEND_BIT   5

`endif

// ---- hdl/dpt_pkg.sv ----
// types shared by the programmed transfer attachment
`include "dpt_params.svh"
package dpt_pkg;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_SELECTED = 6'h02,
        ST_DRIVE    = 6'h04,
        ST_RETURN   = 6'h08,
        ST_RELEASE  = 6'h10,
        ST_FINISH   = 6'h20
    } seq_state_t;

    typedef struct packed {
        logic [`CODE_W-1:0] code;
        logic [`DATA_W-1:0] data;
        logic [`PAR_W-1:0]  par;
    } command_t;

    typedef struct packed {
        logic             accept;
        logic             is_read;
        logic             is_reset;
        logic             is_prepare;
        logic             is_status;
        logic [`CC_W-1:0] cc;
    } verdict_t;

endpackage

// ---- hdl/sig_sync.sv ----
// two-stage synchroniser with edge flags, one lane per bit
`timescale 1ns/1ns
`default_nettype none
module sig_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] q,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] q_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta[i] <= 1'b0;
                    q[i]    <= 1'b0;
                    q_d[i]  <= 1'b0;
                end else begin
                    meta[i] <= din[i];
                    q[i]    <= meta[i];
                    q_d[i]  <= q[i];
                end
            end
            assign rise[i] = q[i] & ~q_d[i];
            assign fall[i] = ~q[i] & q_d[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ---- hdl/cmd_decode.sv ----
// command examination: acceptance, parity and condition code
`timescale 1ns/1ns
`default_nettype none
`include "dpt_params.svh"
module cmd_decode (
    input  wire dpt_pkg::command_t cmd,
    input  wire logic              busy,
    output var  dpt_pkg::verdict_t verdict
);
    wire is_read   = cmd.code[`CMD_DIR_BIT];
    wire is_wr     = cmd.code == `CODE_WRITE_DATA;
    wire is_prep   = cmd.code == `CODE_PREPARE;
    wire is_reset  = cmd.code == `CODE_DEV_RESET;
    wire is_rd     = cmd.code == `CODE_READ_DATA;
    wire is_stat   = cmd.code == `CODE_READ_STAT;
    wire known     = is_wr | is_prep | is_reset | is_rd | is_stat;
    // odd parity on each byte, checked on writes only
    wire par_hi_ok = cmd.par[1] == ~^cmd.data[15:8];
    wire par_lo_ok = cmd.par[0] == ~^cmd.data[7:0];
    wire par_ok    = is_read | (par_hi_ok & par_lo_ok);
    // reset and status reads are honoured even when the user side is busy
    wire blocked   = busy & ~is_reset & ~is_stat;

    wire [`CC_W-1:0] cc = !known  ? `CC_REJECT :
                          !par_ok ? `CC_PARITY :
                          blocked ? `CC_BUSY   : `CC_OK;

    assign verdict.accept     = cc == `CC_OK;
    assign verdict.is_read    = is_read;
    assign verdict.is_reset   = is_reset;
    assign verdict.is_prepare = is_prep;
    assign verdict.is_status  = is_stat;
    assign verdict.cc         = cc;
endmodule
`default_nettype wire

// ---- dv/channel_model.sv ----
// channel-side model that runs programmed transfer sequences on the pins
`timescale 1ns/1ns
`default_nettype none
module channel_model (
    input  wire logic        clk,
    output logic      [15:0] addr,
    output logic             addr_sel,
    output logic      [15:0] data,
    output logic      [1:0]  data_par,
    output logic             gate,
    output logic             strobe,
    input  wire logic        agr,
    input  wire logic [2:0]  cc_in,
    input  wire logic        cc_oe,
    input  wire logic [15:0] dout,
    input  wire logic [1:0]  dpar,
    input  wire logic        data_oe
);
    logic [2:0]  cc;
    logic [15:0] rdata;
    logic [1:0]  rpar;
    logic        got, pre_oe, hold_ok, rel_ok, roe;
    logic        holding = 1'b0;
    logic        prev_oe = 1'b0;
    logic        agr_q = 1'b0;
    int          t_rise, t_fall;

    initial begin
        addr = 16'h0;
        addr_sel = 1'b0;
        data = 16'h0;
        data_par = 2'h0;
        gate = 1'b0;
        strobe = 1'b0;
    end

    // all pin changes land just after the edge, like the bench stimulus
    task automatic step();
        @(posedge clk);
        #1;
        if (holding && (cc_in !== cc || dout !== rdata)) hold_ok = 1'b0;
        if (agr_q && !agr && prev_oe) rel_ok = 1'b0;
        prev_oe = cc_oe | data_oe;
        agr_q = agr;
    endtask

    // one sequence moves one word; skip leaves the strobe out
    task automatic run(input logic [15:0] a, input logic [15:0] d,
                       input logic [1:0] p, input int deskew,
                       input int width, input bit skip);
        int n;
        step();
        addr = a;
        data = d;
        data_par = p;
        addr_sel = 1'b1;
        repeat (deskew) step();
        gate = 1'b1;
        n = 0;
        hold_ok = 1'b1;
        rel_ok = 1'b1;
        pre_oe = 1'b0;
        while (agr !== 1'b1 && n < 80) begin
            pre_oe = cc_oe;
            step();
            n++;
        end
        t_rise = n;
        got = agr;
        cc = got ? cc_in : 3'h0;
        rdata = dout;
        rpar = dpar;
        roe = got & data_oe;
        if (got) begin
            holding = 1'b1;
            if (!skip) begin
                repeat (2) step();
                strobe = 1'b1;
            end
            repeat (width) step();
        end
        gate = 1'b0;
        strobe = 1'b0;
        holding = 1'b0;
        n = 0;
        while (agr !== 1'b0 && n < 80) begin
            step();
            n++;
        end
        t_fall = n;
        step();
        // released lines show a changed value, not the old one
        addr_sel = 1'b0;
        addr = ~addr;
        data = ~data;
        data_par = ~data_par;
        repeat (4) step();
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the programmed transfer attachment
`timescale 1ns/1ns
`default_nettype none
`include "dpt_params.svh"
module testbench;
    logic        CLOCK, SRST, ADDR_SEL_IN, ADDR_GATE, DATA_STROBE;
    logic        MACHINE_CHECK_TAG, USER_BUSY, INT_EVENT, CC_OE, DATA_OE;
    logic        ADDR_GATE_RETURN, CMD_STROBE, DEVICE_RESET;
    logic [15:0] ADDR_IN, DATA_IN, RD_DATA, DATA_OUT, REQUEST_OUT, CMD_DATA;
    logic [1:0]  DATA_PAR_IN, DATA_PAR_OUT;
    logic [7:0]  DEVICE_ADDR, CMD_CODE, c;
    logic [2:0]  CC_OUT;
    logic [31:0] seed = 32'h1a7a5690;
    logic [31:0] r;
    logic [3:0]  lvl = 4'h0;
    logic        en = 1'b0;
    logic        pend = 1'b0;
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          n_strobe = 0;
    int          n_reset = 0;
    logic [7:0]  codes [6] = '{`CODE_WRITE_DATA, `CODE_PREPARE, 8'h40,
        `CODE_DEV_RESET, `CODE_READ_DATA, `CODE_READ_STAT};

    programmed_io_channel_attach i_dut (
        .CLOCK(CLOCK), .SRST(SRST), .ADDR_IN(ADDR_IN),
        .ADDR_SEL_IN(ADDR_SEL_IN), .DATA_IN(DATA_IN),
        .DATA_PAR_IN(DATA_PAR_IN), .ADDR_GATE(ADDR_GATE),
        .DATA_STROBE(DATA_STROBE), .MACHINE_CHECK_TAG(MACHINE_CHECK_TAG),
        .DEVICE_ADDR(DEVICE_ADDR), .RD_DATA(RD_DATA), .USER_BUSY(USER_BUSY),
        .INT_EVENT(INT_EVENT), .ADDR_GATE_RETURN(ADDR_GATE_RETURN),
        .CC_OUT(CC_OUT), .CC_OE(CC_OE), .DATA_OUT(DATA_OUT),
        .DATA_PAR_OUT(DATA_PAR_OUT), .DATA_OE(DATA_OE),
        .REQUEST_OUT(REQUEST_OUT), .CMD_STROBE(CMD_STROBE),
        .CMD_CODE(CMD_CODE), .CMD_DATA(CMD_DATA), .DEVICE_RESET(DEVICE_RESET));

    channel_model i_chan (
        .clk(CLOCK), .addr(ADDR_IN), .addr_sel(ADDR_SEL_IN), .data(DATA_IN),
        .data_par(DATA_PAR_IN), .gate(ADDR_GATE), .strobe(DATA_STROBE),
        .agr(ADDR_GATE_RETURN), .cc_in(CC_OUT), .cc_oe(CC_OE),
        .dout(DATA_OUT), .dpar(DATA_PAR_OUT), .data_oe(DATA_OE));

    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [1:0] oddpar(input logic [15:0] w);
        return {~^w[15:8], ~^w[7:0]};
    endfunction

    function automatic logic [15:0] exp_req();
        return (pend && en) ? (16'h1 << lvl) : 16'h0;
    endfunction

    function automatic logic [2:0] exp_cc(input logic [7:0] k,
            input logic b, input bit bp, input bit sel);
        if (!sel) return `CC_NONE;
        if (!(k inside {`CODE_WRITE_DATA, `CODE_PREPARE, `CODE_DEV_RESET,
                        `CODE_READ_DATA, `CODE_READ_STAT})) return `CC_REJECT;
        if (bp) return `CC_PARITY;
        if (b && k != `CODE_DEV_RESET && k != `CODE_READ_STAT) return `CC_BUSY;
        return `CC_OK;
    endfunction

    task automatic check_val(input string nm, input logic [15:0] e,
                             input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_flag(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // a hang in the handshake ends the run through the same report
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (CMD_STROBE === 1'b1) n_strobe <= n_strobe + 1;
        if (DEVICE_RESET === 1'b1) n_reset <= n_reset + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            final_report();
        end
    end

    task automatic seq(input logic [7:0] k, input logic [7:0] da,
                       input logic busy, input bit bp, input bit skip,
                       input logic [15:0] d);
        logic [2:0]  ecc;
        logic [15:0] rd, st;
        int          s0, r0;
        bit          acc, sel;
        @(posedge CLOCK);
        #1;
        USER_BUSY = busy;
        RD_DATA = 16'(rnd());
        rd = RD_DATA;
        st = {10'h0, pend, en, lvl};
        s0 = n_strobe;
        r0 = n_reset;
        sel = (da == DEVICE_ADDR);
        ecc = exp_cc(k, busy, bp, sel);
        acc = (ecc == `CC_OK);
        i_chan.run({da, k}, d, oddpar(d) ^ {1'b0, bp}, 4 + int'(rnd() % 4),
                   4 + int'(rnd() % 6), skip);
        check_val("cond code", 16'(ecc), 16'(i_chan.cc));
        check_val("strobes", 16'(acc && (k == `CODE_WRITE_DATA ||
                  (k == `CODE_READ_DATA && !skip))), 16'(n_strobe - s0));
        check_val("resets", 16'(acc && k == `CODE_DEV_RESET),
                  16'(n_reset - r0));
        if (acc && k == `CODE_WRITE_DATA) begin
            check_val("cmd code", 16'(k), 16'(CMD_CODE));
            check_val("cmd data", d, CMD_DATA);
        end
        if (acc && k == `CODE_READ_DATA)
            check_val("rd", rd, i_chan.rdata);
        if (acc && k == `CODE_READ_STAT)
            check_val("st", st, i_chan.rdata);
        if (acc && k[7]) check_flag("rpar", 1'b1,
            oddpar(i_chan.rdata) === i_chan.rpar);
        if (acc && k == `CODE_PREPARE) begin
            lvl = d[3:0];
            en = d[4];
        end
        if (acc && k == `CODE_DEV_RESET) pend = 1'b0;
        if (sel) begin
            check_flag("cc first", 1'b1, i_chan.pre_oe);
            check_flag("read oe", acc && k[7], i_chan.roe);
            check_flag("hold", 1'b1, i_chan.hold_ok);
            check_flag("release", 1'b1, i_chan.rel_ok);
            check_flag("rise time", 1'b1, i_chan.t_rise <= 60);
            check_flag("fall time", 1'b1, i_chan.t_fall <= 60);
        end
        check_val("request", exp_req(), REQUEST_OUT);
        $display("test sequence %h done", k);
    endtask

    task automatic pulse(input bit machine_check_tag);
        @(posedge CLOCK);
        #1;
        MACHINE_CHECK_TAG = machine_check_tag;
        INT_EVENT = !machine_check_tag;
        repeat (machine_check_tag ? 3 : 1) @(posedge CLOCK);
        #1;
        MACHINE_CHECK_TAG = 1'b0;
        INT_EVENT = 1'b0;
        pend = !machine_check_tag;
        repeat (4) @(posedge CLOCK);
        #1;
        check_val("request", exp_req(), REQUEST_OUT);
        $display("test event %0d done", machine_check_tag);
    endtask

    initial begin
        SRST = 1'b1;
        USER_BUSY = 1'b0;
        INT_EVENT = 1'b0;
        MACHINE_CHECK_TAG = 1'b0;
        RD_DATA = 16'h0;
        DEVICE_ADDR = 8'(rnd());
        repeat (20) @(posedge CLOCK);
        #1;
        SRST = 1'b0;
        check_val("reset outs", 16'h0, {CC_OE, DATA_OE, ADDR_GATE_RETURN,
                  CC_OUT, REQUEST_OUT[9:0]});
        $display("test reset done");
        seq(`CODE_PREPARE, DEVICE_ADDR, 0, 0, 0, 16'h001b);
        pulse(0);
        seq(`CODE_READ_STAT, DEVICE_ADDR, 1, 0, 0, 16'h0);
        seq(`CODE_DEV_RESET, DEVICE_ADDR, 1, 0, 0, 16'h0);
        seq(`CODE_WRITE_DATA, DEVICE_ADDR ^ 8'h80, 0, 0, 0, 16'h1234);
        seq(`CODE_WRITE_DATA, DEVICE_ADDR, 0, 1, 0, 16'hffff);
        seq(`CODE_READ_DATA, DEVICE_ADDR, 0, 0, 1, 16'h0);
        seq(8'h55, DEVICE_ADDR, 0, 0, 0, 16'h0);
        pulse(0);
        pulse(1);
        seq(`CODE_READ_STAT, DEVICE_ADDR, 0, 0, 0, 16'h0);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            c = codes[r[2:0] % 6];
            seq(c, (r[5:3] == 3'h0) ? DEVICE_ADDR ^ 8'h01 : DEVICE_ADDR,
                r[7:6] == 2'h0, c == `CODE_WRITE_DATA && r[9:8] == 2'h0,
                c == `CODE_READ_DATA && r[11:10] == 2'h0, 16'(rnd()));
            if (r[13:12] == 2'h0) pulse(r[14]);
        end
        final_report();
    end
endmodule
`default_nettype wire
